// ---- rtl/tfp_top.sv ----
// frame alignment and two-frame pipeline of the transcoder
`timescale 1ns/1ps
`default_nettype none
module tfp_top (
    // system clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_b_in,
    // link clock and serial pins
    input  wire logic clk_link_in,
    input  wire logic serial_data_in,
    input  wire logic frame_pulse_in,
    input  wire logic channel_strobe_first_in,
    input  wire logic channel_strobe_second_in,
    input  wire logic synchronous_serial_mode_in,
    output var  logic serial_data_out,
    // frame pipeline
    output var  logic frame_tick_out,
    output var  logic [tfp_pkg::FRAME_W-1:0] frame_work_out,
    output var  logic strobe_fault_out
);
    logic rst_meta, rst_sync;
    logic lrst_meta, lrst_sync;
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end
    always_ff @(posedge clk_link_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lrst_meta <= 1'b0;
            lrst_sync <= 1'b0;
        end else begin
            lrst_meta <= 1'b1;
            lrst_sync <= lrst_meta;
        end
    end

    // link domain: pin synchronisers
    logic fp_s, s1_s, s2_s, mode_s, din_s;
    tfp_sync u_fp   (.clk_in(clk_link_in), .rst_b_in(lrst_sync), .d_in(frame_pulse_in),             .q_out(fp_s));
    tfp_sync u_s1   (.clk_in(clk_link_in), .rst_b_in(lrst_sync), .d_in(channel_strobe_first_in),    .q_out(s1_s));
    tfp_sync u_s2   (.clk_in(clk_link_in), .rst_b_in(lrst_sync), .d_in(channel_strobe_second_in),   .q_out(s2_s));
    tfp_sync u_mode (.clk_in(clk_link_in), .rst_b_in(lrst_sync), .d_in(synchronous_serial_mode_in), .q_out(mode_s));
    tfp_sync u_din  (.clk_in(clk_link_in), .rst_b_in(lrst_sync), .d_in(serial_data_in),             .q_out(din_s));

    // link domain: alignment and shift registers
    logic fp_d, s1_d, s2_d;
    logic ser_armed;
    logic [tfp_pkg::SLOT_CNT_W-1:0] bit_cnt;
    logic [tfp_pkg::FRAME_W-1:0] in_shift, in_frame, out_shift;
    logic link_toggle;
    logic next_ser_armed, next_link_toggle, frame_start, next_dout;
    logic [tfp_pkg::SLOT_CNT_W-1:0] next_bit_cnt;
    logic [tfp_pkg::FRAME_W-1:0] next_in_shift, next_in_frame, next_out_shift;
    logic [tfp_pkg::FRAME_W-1:0] out_hold_l;
    logic out_toggle_s, out_toggle_d;

    always_comb begin
        next_ser_armed = ser_armed;
        frame_start    = 1'b0;
        if (mode_s) begin
            if (s1_s && !s1_d)
                next_ser_armed = 1'b1;
            if (s2_s && !s2_d && ser_armed) begin
                frame_start    = 1'b1;
                next_ser_armed = 1'b0;
            end
        end else begin
            next_ser_armed = 1'b0;
            frame_start    = fp_s && !fp_d;
        end
        next_bit_cnt     = frame_start ? '0 : bit_cnt + 1'b1;
        next_in_shift    = {in_shift[tfp_pkg::FRAME_W-2:0], din_s};
        next_in_frame    = in_frame;
        next_link_toggle = link_toggle;
        next_out_shift   = {out_shift[tfp_pkg::FRAME_W-2:0], 1'b0};
        next_dout        = out_shift[tfp_pkg::FRAME_W-1];
        if (frame_start) begin
            next_in_frame    = in_shift;
            next_link_toggle = !link_toggle;
            next_out_shift   = out_hold_l;
        end
    end
    always_ff @(posedge clk_link_in or negedge lrst_sync) begin
        if (!lrst_sync) begin
            fp_d            <= 1'b0;
            s1_d            <= 1'b0;
            s2_d            <= 1'b0;
            ser_armed       <= 1'b0;
            bit_cnt         <= '0;
            in_shift        <= tfp_pkg::FRAME_RST;
            in_frame        <= tfp_pkg::FRAME_RST;
            out_shift       <= tfp_pkg::FRAME_RST;
            link_toggle     <= 1'b0;
            serial_data_out <= 1'b0;
        end else begin
            fp_d            <= fp_s;
            s1_d            <= s1_s;
            s2_d            <= s2_s;
            ser_armed       <= next_ser_armed;
            bit_cnt         <= next_bit_cnt;
            in_shift        <= next_in_shift;
            in_frame        <= next_in_frame;
            out_shift       <= next_out_shift;
            link_toggle     <= next_link_toggle;
            serial_data_out <= next_dout;
        end
    end

    // system domain: frame event crossing and two stage pipeline
    logic tog_s, tog_d;
    logic [tfp_pkg::FRAME_W-1:0] work, out_hold;
    logic s1_sys, s2_sys, s1_sd, s2_sd;
    logic [tfp_pkg::GAP_CNT_W-1:0] gap1, gap2;
    tfp_pkg::tfp_strobe_t order;
    logic frame_ev;
    logic next_tick, next_fault;
    logic [tfp_pkg::FRAME_W-1:0] next_work, next_out_hold;
    logic [tfp_pkg::GAP_CNT_W-1:0] next_gap1, next_gap2;
    tfp_pkg::tfp_strobe_t next_order;
    logic rise1, rise2;

    tfp_sync u_tog (.clk_in(clk_sys_in), .rst_b_in(rst_sync), .d_in(link_toggle),             .q_out(tog_s));
    tfp_sync u_t1  (.clk_in(clk_sys_in), .rst_b_in(rst_sync), .d_in(channel_strobe_first_in),  .q_out(s1_sys));
    tfp_sync u_t2  (.clk_in(clk_sys_in), .rst_b_in(rst_sync), .d_in(channel_strobe_second_in), .q_out(s2_sys));

    always_comb begin
        frame_ev      = tog_s != tog_d;
        next_work     = work;
        next_out_hold = out_hold;
        // in_frame is stable for a whole frame after the toggle, so it is safe to sample
        if (frame_ev) begin
            next_work     = in_frame;
            next_out_hold = in_frame;
        end
        next_tick  = frame_ev;
        rise1      = s1_sys && !s1_sd;
        rise2      = s2_sys && !s2_sd;
        next_gap1  = rise1 ? '0 : (gap1 == tfp_pkg::GAP_MIN ? gap1 : gap1 + 1'b1);
        next_gap2  = rise2 ? '0 : (gap2 == tfp_pkg::GAP_MIN ? gap2 : gap2 + 1'b1);
        next_order = order;
        next_fault = strobe_fault_out;
        if (rise1) begin
            if (gap1 < tfp_pkg::GAP_MIN - 1'b1 || order != tfp_pkg::TFP_EXPECT_FIRST)
                next_fault = 1'b1;
            next_order = tfp_pkg::TFP_EXPECT_SECOND;
        end
        if (rise2) begin
            if (gap2 < tfp_pkg::GAP_MIN - 1'b1 || order != tfp_pkg::TFP_EXPECT_SECOND)
                next_fault = 1'b1;
            next_order = tfp_pkg::TFP_EXPECT_FIRST;
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_sync) begin
        if (!rst_sync) begin
            tog_d            <= 1'b0;
            work             <= tfp_pkg::FRAME_RST;
            out_hold         <= tfp_pkg::FRAME_RST;
            frame_tick_out   <= 1'b0;
            frame_work_out   <= tfp_pkg::FRAME_RST;
            s1_sd            <= 1'b0;
            s2_sd            <= 1'b0;
            gap1             <= tfp_pkg::GAP_MIN;
            gap2             <= tfp_pkg::GAP_MIN;
            order            <= tfp_pkg::TFP_EXPECT_FIRST;
            strobe_fault_out <= 1'b0;
        end else begin
            tog_d            <= tog_s;
            work             <= next_work;
            out_hold         <= next_out_hold;
            frame_tick_out   <= next_tick;
            frame_work_out   <= next_work;
            s1_sd            <= s1_sys;
            s2_sd            <= s2_sys;
            gap1             <= next_gap1;
            gap2             <= next_gap2;
            order            <= next_order;
            strobe_fault_out <= next_fault;
        end
    end

    // output words back to the link domain, stable for a frame before use
    tfp_sync u_ot (.clk_in(clk_link_in), .rst_b_in(lrst_sync), .d_in(tog_d), .q_out(out_toggle_s));
    always_ff @(posedge clk_link_in or negedge lrst_sync) begin
        if (!lrst_sync) begin
            out_toggle_d <= 1'b0;
            out_hold_l   <= tfp_pkg::FRAME_RST;
        end else begin
            out_toggle_d <= out_toggle_s;
            out_hold_l   <= (out_toggle_s != out_toggle_d) ? out_hold : out_hold_l;
        end
    end
endmodule : tfp_top
`default_nettype wire

// ---- pkg/tfp_pkg.sv ----
// shared constants and types of the transcoder frame pipeline
package tfp_pkg;
    localparam int unsigned CHANNELS      = 4;
    localparam int unsigned WORD_W        = 8;
    localparam int unsigned FRAME_W       = CHANNELS * WORD_W;
    localparam int unsigned SLOT_CNT_W    = 5;
    localparam logic [SLOT_CNT_W-1:0] SLOT_LAST = 5'h1f;
    localparam int unsigned STROBE_MIN_CYC = 512;
    localparam int unsigned GAP_CNT_W     = 10;
    localparam logic [GAP_CNT_W-1:0] GAP_MIN = 10'h200;
    localparam logic [FRAME_W-1:0] FRAME_RST = 32'h0000_0000;
    typedef enum logic [1:0] {
        TFP_EXPECT_FIRST,
        TFP_EXPECT_SECOND
    } tfp_strobe_t;
endpackage : tfp_pkg

// ---- rtl/tfp_sync.sv ----
// two-flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module tfp_sync (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    // level
    input  wire logic d_in,
    output var  logic q_out
);
    logic meta;
    logic next_meta;
    logic next_q;
    always_comb begin
        next_meta = d_in;
        next_q    = meta;
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta  <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta  <= next_meta;
            q_out <= next_q;
        end
    end
endmodule : tfp_sync
`default_nettype wire

// ---- tb/tfp_far_end.sv ----
// far-end serial source for the frame pipeline
`timescale 1ns/1ps
`default_nettype none
module tfp_far_end (
    // free link clock and controls
    input  wire logic        lclk_in,
    input  wire logic        run_in,
    input  wire logic        ssi_in,
    input  wire logic        bad_in,
    input  wire logic [31:0] word_in,
    // serial pins and frame count
    output var  logic        clk_link_out,
    output var  logic        data_out,
    output var  logic        pulse_out,
    output var  logic        first_out,
    output var  logic        second_out,
    output var  int          frame_out
);
    int   cnt = 0;
    logic gate = 1'b0;
    logic on;
    assign clk_link_out = lclk_in & gate;
    assign on = run_in && cnt < 32;
    initial begin
        {data_out, pulse_out, first_out, second_out} = 4'h0;
        frame_out = 0;
    end
    // clock stands still between frames, strobes alternate unless bad_in is set
    always @(negedge lclk_in) begin
        gate       <= on;
        data_out   <= on ? word_in[31 - cnt] : ~data_out;
        pulse_out  <= run_in && !ssi_in && frame_out > 0 && cnt == 0;
        first_out  <= run_in && ssi_in && (cnt == 16 || bad_in && cnt == 0);
        second_out <= run_in && ssi_in && !bad_in && frame_out > 0 && cnt == 0;
        cnt        <= (!run_in || cnt == 331) ? 0 : cnt + 1;
        frame_out  <= !run_in ? 0 : frame_out + int'(cnt == 331);
    end
endmodule : tfp_far_end
`default_nettype wire

// ---- tb/tfp_top_props.sv ----
// port assertions of the frame pipeline
`timescale 1ns/1ps
`default_nettype none
module tfp_top_props (
    // watched ports
    input wire logic                        clk_sys_in,
    input wire logic                        rst_b_in,
    input wire logic                        frame_pulse_in,
    input wire logic                        synchronous_serial_mode_in,
    input wire logic                        frame_tick_out,
    input wire logic [tfp_pkg::FRAME_W-1:0] frame_work_out,
    input wire logic                        strobe_fault_out
);
    logic [7:0] gap;
    logic [7:0] next_gap;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    always_comb next_gap = frame_tick_out ? 8'h00 : (gap == 8'hff ? gap : gap + 8'h01);
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) gap <= 8'hff;
        else gap <= next_gap;
    end
    sequence s_pulse_rise;
        !synchronous_serial_mode_in && $rose(frame_pulse_in);
    endsequence
    a_pulse_gives_tick:
        assert property (s_pulse_rise |-> ##[1:20] frame_tick_out) else $error("no tick after frame pulse");
    a_tick_one_cycle:
        assert property (frame_tick_out |=> !frame_tick_out) else $error("tick longer than one cycle");
    a_work_at_tick:
        assert property ($changed(frame_work_out) |-> frame_tick_out || $past(frame_tick_out))
        else $error("frame work changed between ticks");
    a_tick_whole_frame:
        assert property (frame_tick_out |-> gap >= 8'h2d) else $error("ticks closer than a frame");
    a_fault_sticky:
        assert property (strobe_fault_out |=> strobe_fault_out) else $error("strobe fault dropped");
endmodule : tfp_top_props
bind tfp_top tfp_top_props u_tfp_top_props (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .frame_pulse_in(frame_pulse_in), .synchronous_serial_mode_in(synchronous_serial_mode_in),
    .frame_tick_out(frame_tick_out), .frame_work_out(frame_work_out), .strobe_fault_out(strobe_fault_out));
`default_nettype wire

// ---- tb/tfp_top_bench.sv ----
// self-checking bench of the frame pipeline
`timescale 1ns/1ps
`default_nettype none
module tfp_top_bench;
    logic        clk_sys = 1'b0;
    logic        lclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        synchronous_serial_mode = 1'b0;
    logic        bad = 1'b0;
    logic        run = 1'b0;
    logic        clk_link, sdi, pulse, s1, s2, sdo, tick, fault;
    logic [31:0] work;
    int          frame, nedge, num_errors, samples_checked;
    logic        obits [0:4095];
    always #20 clk_sys = ~clk_sys;
    initial begin
        #7;
        forever #32 lclk = ~lclk;
    end
    function automatic logic [31:0] wfn(input int k);
        return 32'h9e37_79b9 * (k + 1);
    endfunction : wfn
    tfp_top u_tfp_top (.clk_sys_in(clk_sys), .rst_b_in(rst_b), .clk_link_in(clk_link), .serial_data_in(sdi),
        .frame_pulse_in(pulse), .channel_strobe_first_in(s1), .channel_strobe_second_in(s2),
        .synchronous_serial_mode_in(synchronous_serial_mode), .serial_data_out(sdo), .frame_tick_out(tick),
        .frame_work_out(work), .strobe_fault_out(fault));
    tfp_far_end u_tfp_far_end (.lclk_in(lclk), .run_in(run), .ssi_in(synchronous_serial_mode), .bad_in(bad), .word_in(wfn(frame)),
        .clk_link_out(clk_link), .data_out(sdi), .pulse_out(pulse), .first_out(s1), .second_out(s2),
        .frame_out(frame));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // first frame after reset is partly lost in the link synchronisers
    always @(negedge clk_sys) begin
        if (run && tick === 1'b1 && frame > 1) chk("frame work", wfn(frame - 1), work);
    end
    always @(negedge clk_link) begin
        if (nedge < 4096) obits[nedge] = sdo;
        nedge++;
    end
    task automatic run_test(input string name, input logic mode, input logic wrong);
        logic [31:0] got;
        rst_b <= 1'b0;
        run <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        synchronous_serial_mode <= mode;
        bad <= wrong;
        nedge = 0;
        repeat (10) @(posedge clk_sys);
        run <= 1'b1;
        wait (frame == 8);
        for (int k = 1; k < 5; k++) begin
            // msb leaves on the fourth link edge of the frame two frames on
            for (int b = 0; b < 32; b++) got[31 - b] = obits[32 * (k + 2) + 3 + b];
            if (!wrong) chk("serial out", wfn(k), got);
        end
        chk("strobe fault", {31'h0, wrong}, {31'h0, fault});
        $display("test %s done", name);
    endtask : run_test
    task automatic end_sim();
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    initial begin
        run_test("frame pulse", 1'b0, 1'b0);
        run_test("strobes", 1'b1, 1'b0);
        run_test("strobe order", 1'b1, 1'b1);
        end_sim();
    end
    // three runs of eight long frames take about 0.51 ms
    initial begin
        #1000000;
        num_errors++;
        end_sim();
    end
endmodule : tfp_top_bench
`default_nettype wire
